// *** logic/ppc_cfg.svh ***
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// Port geometry
`define PPC_PORT_W 16
`define PPC_ANA_W 16
// Analog select reset value: zero means analog
`define PPC_ANA_RST 16'h0000
`define PPC_DIR_RST 16'hFFFF
`define PPC_LAT_RST 16'h0000
`define PPC_ZERO 16'h0000
// Pins with open-drain capability (upper byte; analog select covers them too)
`define PPC_OD_CAPABLE 16'hFF00
`endif

// *** logic/ppc_pkg.sv ***
`include "ppc_cfg.svh"
package ppc_pkg;
  typedef logic [`PPC_PORT_W-1:0] ppc_word_type;
  // Software write command for one port register
  typedef struct packed {
    logic we_latch;
    logic we_dir;
    logic we_od;
    logic we_ana_lo;
    logic we_ana_hi;
    ppc_word_type data;
  } ppc_wr_type;
  // Pin-side drive
  typedef struct packed {
    ppc_word_type out;
    ppc_word_type oe;
  } ppc_pad_type;
  // Whole module state
  typedef struct packed {
    ppc_word_type latch_r;
    ppc_word_type dir_r;
    ppc_word_type od_r;
    ppc_word_type ana_lo_r;
    ppc_word_type ana_hi_r;
    ppc_word_type s1_r;
    ppc_word_type s2_r;
    ppc_word_type s3_r;
    ppc_word_type stable_r;
    ppc_word_type rd_r;
    ppc_word_type pad_out_r;
    ppc_word_type pad_oe_r;
    ppc_word_type conv_r;
    ppc_word_type ana_sel_r;
  } ppc_state_type;
endpackage

// *** logic/ppc_port_pin_config.sv ***
`include "ppc_cfg.svh"
// Summary of operation
// [R1] Open-drain bit set: pin drives low only, else released; clear: push-pull output.
// [R2] Open-drain choice exists only on the capable digital-only pin subset; the code also lets those pins be selected analog.
// [R3] Software sets direction to input for pins used as analog channels.
// [R4] Analog pin set to output: converter sees the pin's own driven level.
// [R5] Both analog select registers reset to zero, so shared pins start analog.
// [R6] Port read returns zero for every pin configured as analog input.
// [R7] Pins configured digital are never offered to the converter.
// [R8] Port read reflects a write or direction change one cycle later at least.
// [R9] Software places a no-operation between port write and following read.
// [R10] Writes load the output latch; port reads return synchronized pin levels.
module ppc_port_pin_config
  import ppc_pkg::*;
#(
  parameter int PORT_W = `PPC_PORT_W
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Software register writes
  input wire ppc_wr_type i_wr,
  // Pin inputs
  input wire ppc_word_type i_pad_in,
  // Pin drive
  output ppc_pad_type o_pad,
  // Register read-back
  output ppc_word_type o_pin_level,
  output ppc_word_type o_latch,
  output ppc_word_type o_dir,
  output ppc_word_type o_od,
  // Converter side
  output ppc_word_type o_ana_sel,
  output ppc_word_type o_conv_level
);
  ppc_state_type st_r;
  ppc_state_type st_nxt;
  ppc_word_type ana_cfg;
  ppc_word_type pad_val;
  ppc_word_type od_eff;

  always_comb
  begin
    st_nxt = st_r;
    // [R10] Latch writes
    if (i_wr.we_latch)
    begin
      st_nxt.latch_r = i_wr.data;
    end
    if (i_wr.we_dir)
    begin
      st_nxt.dir_r = i_wr.data;
    end
    // [R2] Capable pins only
    if (i_wr.we_od)
    begin
      st_nxt.od_r = i_wr.data & `PPC_OD_CAPABLE;
    end
    if (i_wr.we_ana_lo)
    begin
      st_nxt.ana_lo_r = i_wr.data;
    end
    if (i_wr.we_ana_hi)
    begin
      st_nxt.ana_hi_r = i_wr.data;
    end
    // Low and high words both cover every pin; a zero bit in either word selects analog
    ana_cfg = ~(st_r.ana_lo_r & st_r.ana_hi_r);
    od_eff = st_r.od_r;
    // [R1] Open-drain drive
    st_nxt.pad_out_r = st_r.latch_r & ~od_eff;
    st_nxt.pad_oe_r = ~st_r.dir_r & ~(od_eff & st_r.latch_r);
    // [R8] Read lags pin and write
    // Three-stage sync; accept a change once stages two and three agree
    st_nxt.s1_r = i_pad_in;
    st_nxt.s2_r = st_r.s1_r;
    st_nxt.s3_r = st_r.s2_r;
    pad_val = st_r.stable_r;
    for (int i = 0; i < PORT_W; i++)
    begin
      if (st_r.s2_r[i] == st_r.s3_r[i])
      begin
        pad_val[i] = st_r.s3_r[i];
      end
    end
    st_nxt.stable_r = pad_val;
    // [R6] Analog input pins read zero
    st_nxt.rd_r = pad_val & ~(ana_cfg & st_r.dir_r);
    // [R7] Digital pins not converted
    st_nxt.ana_sel_r = ana_cfg;
    // [R4] Output level converted when driven
    for (int i = 0; i < PORT_W; i++)
    begin
      if (ana_cfg[i] && !st_r.dir_r[i])
      begin
        st_nxt.conv_r[i] = st_r.pad_out_r[i] | (od_eff[i] & ~st_r.pad_oe_r[i]);
      end
      else
      begin
        st_nxt.conv_r[i] = ana_cfg[i] & pad_val[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
      st_r.dir_r <= `PPC_DIR_RST;
      st_r.latch_r <= `PPC_LAT_RST;
      // [R5] Analog after reset
      st_r.ana_lo_r <= `PPC_ANA_RST;
      st_r.ana_hi_r <= `PPC_ANA_RST;
      // Select output agrees with zero selects from the first edge
      st_r.ana_sel_r <= ~`PPC_ANA_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_pad.out = st_r.pad_out_r;
  assign o_pad.oe = st_r.pad_oe_r;
  assign o_pin_level = st_r.rd_r;
  assign o_latch = st_r.latch_r;
  assign o_dir = st_r.dir_r;
  assign o_od = st_r.od_r;
  assign o_ana_sel = st_r.ana_sel_r;
  assign o_conv_level = st_r.conv_r;

  // [R1] Open-drain never drives high
  property p_od_no_high;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      st_r.od_r != `PPC_ZERO
        |=> (o_pad.oe & o_pad.out & $past(st_r.od_r)) == `PPC_ZERO;
  endproperty
  a_od_no_high: assert property (p_od_no_high) else $error("open-drain drove high"); // [R1]

  // [R2] Non-capable pins never open-drain
  property p_od_subset;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (st_r.od_r & ~`PPC_OD_CAPABLE) == `PPC_ZERO;
  endproperty
  a_od_subset: assert property (p_od_subset) else $error("open-drain on incapable pin"); // [R2]

  // [R5] Reset gives analog
  property p_ana_reset;
    @(posedge i_ref_clk) !i_rst_n |=> st_r.ana_lo_r == `PPC_ZERO && st_r.ana_hi_r == `PPC_ZERO;
  endproperty
  a_ana_reset: assert property (p_ana_reset) else $error("analog select not zero"); // [R5]

  // [R6] Analog input reads zero
  property p_ana_read_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (st_r.ana_sel_r[0] && st_r.dir_r[0]) ##1 (st_r.ana_sel_r[0] && st_r.dir_r[0])
        |-> !o_pin_level[0];
  endproperty
  a_ana_read_zero: assert property (p_ana_read_zero) else $error("analog pin read high"); // [R6]

  // [R7] Digital pin not selected
  property p_dig_no_conv;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (st_r.ana_lo_r & st_r.ana_hi_r) != `PPC_ZERO
        |=> (o_ana_sel & $past(st_r.ana_lo_r & st_r.ana_hi_r)) == `PPC_ZERO;
  endproperty
  a_dig_no_conv: assert property (p_dig_no_conv) else $error("digital pin converted"); // [R7]

  // [R10] Latch write lands
  property p_latch_write;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_wr.we_latch |=> o_latch == $past(i_wr.data);
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch write lost"); // [R10]

  // [R8] Drive follows latch next cycle
  property p_drive_delay;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_wr.we_latch && !i_wr.data[0] |=> ##1 !o_pad.out[0];
  endproperty
  a_drive_delay: assert property (p_drive_delay) else $error("drive not updated"); // [R8]

  // [R4] Driven analog pin converts own level
  property p_conv_own;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !(st_r.ana_lo_r[1] && st_r.ana_hi_r[1]) && !st_r.dir_r[1] && !st_r.od_r[1]
        |=> o_conv_level[1] == $past(st_r.pad_out_r[1]);
  endproperty
  a_conv_own: assert property (p_conv_own) else $error("converted level wrong"); // [R4]

  c_od_write: cover property (@(posedge i_ref_clk) i_wr.we_od && i_wr.data[15]);
  c_dig_cfg: cover property (@(posedge i_ref_clk) i_wr.we_ana_lo && i_wr.data != `PPC_ZERO);
  c_out_drive: cover property (@(posedge i_ref_clk) o_pad.oe != `PPC_ZERO);
  c_ana_out: cover property (@(posedge i_ref_clk) (o_ana_sel & ~o_dir) != `PPC_ZERO);
  c_od_release: cover property (@(posedge i_ref_clk) (o_od & o_latch & ~o_dir) != `PPC_ZERO);

  // [R7] No level for digital pins
  property p_conv_dig;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (o_conv_level & ~o_ana_sel) == `PPC_ZERO;
  endproperty
  a_conv_dig: assert property (p_conv_dig) else $error("digital converted"); // [R7]

  // [R8] Direction reaches drive later
  property p_dir_delay;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_wr.we_dir |=> ##1 (o_pad.oe & $past(i_wr.data, 2)) == `PPC_ZERO;
  endproperty
  a_dir_delay: assert property (p_dir_delay) else $error("direction not applied"); // [R8]

  // [R5] Pins analog after reset
  property p_sel_reset;
    @(posedge i_ref_clk) !i_rst_n |=> o_ana_sel == ~`PPC_ANA_RST;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("pins not analog"); // [R5]

  // [R1] Clear bit gives push-pull
  property p_push_pull;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      st_r.od_r == `PPC_ZERO
        |=> o_pad.out == $past(st_r.latch_r) && o_pad.oe == ~$past(st_r.dir_r);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong"); // [R1]
endmodule

// *** verif/ppc_port_pin_config_test.sv ***
`include "ppc_cfg.svh"
module ppc_port_pin_config_test
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk;
  logic i_rst_n;
  ppc_wr_type wr;
  ppc_word_type pad_in, lat, dir, od, lo, hi, odm, asel, oe, pin_lvl, lat_q, dir_q, od_q, sel_q, conv;
  ppc_pad_type pad;
  int n_fail, n_checks, i;
  integer seed = 32'he2d6;
  ppc_port_pin_config i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wr(wr),
    .i_pad_in(pad_in), .o_pad(pad), .o_pin_level(pin_lvl), .o_latch(lat_q), .o_dir(dir_q),
    .o_od(od_q), .o_ana_sel(sel_q), .o_conv_level(conv));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input ppc_word_type seen, input ppc_word_type exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Expected values from the rules
  function automatic ppc_word_type f_sel(input ppc_word_type lo_w, input ppc_word_type hi_w);
    return ~(lo_w & hi_w);
  endfunction
  function automatic ppc_word_type f_oe(input ppc_word_type dir_w, input ppc_word_type od_w,
    input ppc_word_type lat_w);
    return ~dir_w & ~(od_w & `PPC_OD_CAPABLE & lat_w);
  endfunction
  // One strobe, then read-back one edge later
  task automatic put(input int k, input ppc_word_type d);
    @(posedge i_ref_clk);
    wr <= ppc_wr_type'({5'h10 >> k, d});
    @(posedge i_ref_clk);
    wr <= '0;
    #1;
    if (k == 0) chk(lat_q, d);
    if (k == 1) chk(dir_q, d);
    if (k == 2) chk(od_q, d & `PPC_OD_CAPABLE);
  endtask
  // Full setup; output pins loop back, released open-drain pins pulled up
  task automatic cfg(input ppc_word_type a, b, c, d, e, x);
    lat = a;
    dir = b;
    od = c;
    lo = d;
    hi = e;
    put(0, a);
    put(1, b);
    put(2, c);
    put(3, d);
    put(4, e);
    odm = od & `PPC_OD_CAPABLE;
    asel = f_sel(lo, hi);
    oe = f_oe(dir, od, lat);
    @(posedge i_ref_clk);
    pad_in <= (~dir & lat) | (dir & x);
    repeat (8) @(posedge i_ref_clk);
    #1;
    chk(pad.oe, oe);
    chk(pad.out & oe, lat & ~odm & oe);
    chk(sel_q, asel);
    chk(pin_lvl, pad_in & ~(asel & dir));
    chk(pin_lvl & ~asel, pad_in & ~asel);
    chk(conv & ~asel, 16'h0000);
    chk(conv & asel & ~dir, lat & asel & ~dir);
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    wr = '0;
    pad_in = 16'h0000;
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    #1;
    chk(lat_q, 16'h0000);
    chk(dir_q, 16'hffff);
    chk(od_q, 16'h0000);
    chk(sel_q, 16'hffff);
    chk(pad.oe, 16'h0000);
    chk(pin_lvl, 16'h0000);
    // Corner cases: open-drain on every capable pin, then all digital outputs
    cfg(16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h0000);
    cfg(16'ha5c3, 16'h0000, 16'h0000, 16'hffff, 16'hffff, 16'h0000);
    cfg(16'h0f0f, 16'hffff, 16'h0000, 16'h00ff, 16'hff00, 16'h3c3c);
    for (i = 0; i < 150; i++)
      cfg(16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 16'($random(seed)),
        16'($random(seed)), 16'($random(seed)));
    close_out();
  end
  // Watchdog well past the expected run length
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    n_fail++;
    close_out();
  end
endmodule
